// ==== verilog/lpf_fragmenter.sv ====
`timescale 1ns/1ps
module lpf_fragmenter #(
	parameter int ADDR_W = 8,
	parameter int VNID_W = 12
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              pkt_valid,
	output logic                   pkt_ready,
	input  wire logic [11:0]       pkt_len,
	input  wire logic [15:0]       pkt_ptype,
	input  wire logic [VNID_W-1:0] pkt_vnid,
	input  wire logic              pkt_signalling,
	input  wire logic              sdu_valid,
	output logic                   sdu_ready,
	input  wire logic [7:0]        sdu_data,
	input  wire logic              frm_valid,
	output logic                   frm_ready,
	input  wire logic [10:0]       frm_bytes,
	input  wire logic [7:0]        frm_assign_id,
	output logic                   out_valid,
	input  wire logic              out_ready,
	output logic [7:0]             out_data,
	output logic                   out_last
);
	logic [31:0]        ctrl_ff, nxt_ctrl, defvn_ff, nxt_defvn, assign_ff, nxt_assign;
	logic               bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
	logic [1:0]         bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
	logic [31:0]        rdata_ff, nxt_rdata;
	logic               wr_go, rd_go, logon;
	lpf_pkg::lpf_state_t st_ff, nxt_st;
	logic [10:0]        rem_ff, nxt_rem, seglen_ff, nxt_seglen, cnt_ff, nxt_cnt;
	logic               usable_ff, nxt_usable, act_ff, nxt_act, usecrc_ff, nxt_usecrc;
	logic               lab_ff, nxt_lab, supp_ff, nxt_supp, sig_ff, nxt_sig;
	logic               seg_s_ff, nxt_seg_s, seg_e_ff, nxt_seg_e;
	logic [2:0]         tag_ff, nxt_tag;
	logic [11:0]        plen_ff, nxt_plen, pos_ff, nxt_pos, sdulen_ff, nxt_sdulen;
	logic [15:0]        ptype_ff, nxt_ptype, pktcnt_ff, nxt_pktcnt;
	logic [7:0]         lbl_ff, nxt_lbl, busy_ff, nxt_busy;
	logic [31:0]        crc_ff, nxt_crc;
	logic [7:0]         seq_ff [lpf_pkg::LPF_TAGS];
	logic [7:0]         nxt_seq [lpf_pkg::LPF_TAGS];
	logic               out_valid_ff, nxt_out_valid, out_last_ff, nxt_out_last;
	logic [7:0]         out_data_ff, nxt_out_data;
	logic               adv, emit, seg_fin, id_hit, any_vld, has_free, n_lab, byte_ok;
	logic [2:0]         free_tag;
	logic [11:0]        hb, lb, sb, left, rem12, d, n_hb, n_base, n_total, trl;
	logic [7:0]         ebyte;
	logic [1:0]         ltype;

	// AXI4-Lite slave: write address and data are taken together
	assign wr_go         = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
	assign rd_go         = s_axi_arvalid && !rvalid_ff;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rresp   = rresp_ff;
	assign s_axi_rdata   = rdata_ff;
	// Logon is a write-one strobe, never stored
	assign logon = wr_go && s_axi_awaddr == ADDR_W'(lpf_pkg::LPF_OFF_CTRL) && s_axi_wstrb[0]
		&& s_axi_wdata[lpf_pkg::LPF_CTRL_LOGON];

	always_comb begin
		nxt_ctrl   = ctrl_ff;
		nxt_defvn  = defvn_ff;
		nxt_assign = assign_ff;
		nxt_bvalid = bvalid_ff && !s_axi_bready;
		nxt_bresp  = bresp_ff;
		nxt_rvalid = rvalid_ff && !s_axi_rready;
		nxt_rresp  = rresp_ff;
		nxt_rdata  = rdata_ff;
		if (wr_go) begin
			nxt_bvalid = 1'b1;
			nxt_bresp  = lpf_pkg::LPF_RESP_OKAY;
			case (s_axi_awaddr)
				ADDR_W'(lpf_pkg::LPF_OFF_CTRL): begin
					nxt_ctrl = lpf_pkg::lpf_strb(ctrl_ff, s_axi_wdata & 32'h0000_001f, s_axi_wstrb);
				end
				ADDR_W'(lpf_pkg::LPF_OFF_DEFVN): begin
					nxt_defvn = lpf_pkg::lpf_strb(defvn_ff, s_axi_wdata, s_axi_wstrb);
				end
				ADDR_W'(lpf_pkg::LPF_OFF_ASSIGN): begin
					nxt_assign = lpf_pkg::lpf_strb(assign_ff, s_axi_wdata & 32'h07ff_ffff,
						s_axi_wstrb);
				end
				ADDR_W'(lpf_pkg::LPF_OFF_STATUS), ADDR_W'(lpf_pkg::LPF_OFF_PKTCNT): begin
					nxt_bresp = lpf_pkg::LPF_RESP_OKAY;
				end
				default: begin
					nxt_bresp = lpf_pkg::LPF_RESP_SLVERR;
				end
			endcase
		end
		if (rd_go) begin
			nxt_rvalid = 1'b1;
			nxt_rresp  = lpf_pkg::LPF_RESP_OKAY;
			case (s_axi_araddr)
				ADDR_W'(lpf_pkg::LPF_OFF_CTRL):   nxt_rdata = ctrl_ff;
				ADDR_W'(lpf_pkg::LPF_OFF_DEFVN):  nxt_rdata = defvn_ff;
				ADDR_W'(lpf_pkg::LPF_OFF_ASSIGN): nxt_rdata = assign_ff;
				ADDR_W'(lpf_pkg::LPF_OFF_STATUS): begin
					nxt_rdata = {16'h0000, st_ff, usecrc_ff, act_ff, tag_ff, busy_ff};
				end
				ADDR_W'(lpf_pkg::LPF_OFF_PKTCNT): nxt_rdata = {16'h0000, pktcnt_ff};
				default: begin
					nxt_rdata = 32'h0000_0000;
					nxt_rresp = lpf_pkg::LPF_RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff   <= lpf_pkg::LPF_CTRL_RST;
			defvn_ff  <= lpf_pkg::LPF_DEFVN_RST;
			assign_ff <= lpf_pkg::LPF_ASSIGN_RST;
			bvalid_ff <= 1'b0;
			bresp_ff  <= lpf_pkg::LPF_RESP_OKAY;
			rvalid_ff <= 1'b0;
			rresp_ff  <= lpf_pkg::LPF_RESP_OKAY;
			rdata_ff  <= 32'h0000_0000;
		end else begin
			ctrl_ff   <= nxt_ctrl;
			defvn_ff  <= nxt_defvn;
			assign_ff <= nxt_assign;
			bvalid_ff <= nxt_bvalid;
			bresp_ff  <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rresp_ff  <= nxt_rresp;
			rdata_ff  <= nxt_rdata;
		end
	end

	// Frame usability and tag allocation
	always_comb begin
		id_hit   = 1'b0;
		any_vld  = 1'b0;
		has_free = 1'b0;
		free_tag = 3'h0;
		for (int i = 0; i < lpf_pkg::LPF_ASSIGN_N; i++) begin
			if (assign_ff[lpf_pkg::LPF_ASSIGN_VLD + i]) begin
				any_vld = 1'b1;
				if (assign_ff[8*i +: 8] == frm_assign_id) begin
					id_hit = 1'b1;
				end
			end
		end
		for (int i = lpf_pkg::LPF_TAGS - 1; i >= 0; i--) begin
			if (!busy_ff[i]) begin
				has_free = 1'b1;
				free_tag = 3'(i);
			end
		end
	end

	assign out_valid = out_valid_ff;
	assign out_data  = out_data_ff;
	assign out_last  = out_last_ff;
	assign adv       = !out_valid_ff || out_ready;
	assign hb        = supp_ff ? 12'h000 : lpf_pkg::LPF_PT_BYTES;
	assign lb        = hb + {11'h000, lab_ff};
	assign sb        = lb + sdulen_ff;
	assign left      = plen_ff - pos_ff;
	assign rem12     = {1'b0, rem_ff};
	assign n_hb      = ctrl_ff[lpf_pkg::LPF_CTRL_SUPP] ? 12'h000 : lpf_pkg::LPF_PT_BYTES;
	assign n_lab     = !pkt_signalling && ctrl_ff[lpf_pkg::LPF_CTRL_LBL_ONE]
		&& ctrl_ff[lpf_pkg::LPF_CTRL_VN_EN] && pkt_vnid != defvn_ff[VNID_W-1:0];
	assign n_base    = n_hb + {11'h000, n_lab} + pkt_len;
	// Check value preferred over sequence number when both are allowed
	assign trl       = ctrl_ff[lpf_pkg::LPF_CTRL_ALLOW_CRC] ? lpf_pkg::LPF_CRC_BYTES
		: lpf_pkg::LPF_SEQ_BYTES;
	assign n_total   = n_base + trl;
	assign ltype     = lab_ff ? lpf_pkg::LPF_LT_ONE : (sig_ff ? lpf_pkg::LPF_LT_SIG
		: lpf_pkg::LPF_LT_NONE);
	assign seg_fin   = st_ff == lpf_pkg::LPF_ST_BODY && emit && cnt_ff == 11'h001;

	always_comb begin
		nxt_st = st_ff;        nxt_rem = rem_ff;       nxt_usable = usable_ff;
		nxt_act = act_ff;      nxt_usecrc = usecrc_ff; nxt_lab = lab_ff;
		nxt_supp = supp_ff;    nxt_sig = sig_ff;       nxt_seg_s = seg_s_ff;
		nxt_seg_e = seg_e_ff;  nxt_tag = tag_ff;       nxt_plen = plen_ff;
		nxt_pos = pos_ff;      nxt_sdulen = sdulen_ff; nxt_ptype = ptype_ff;
		nxt_pktcnt = pktcnt_ff; nxt_lbl = lbl_ff;      nxt_busy = busy_ff;
		nxt_crc = crc_ff;      nxt_seglen = seglen_ff; nxt_cnt = cnt_ff;
		nxt_seq = seq_ff;
		nxt_out_valid = adv ? 1'b0 : out_valid_ff;
		nxt_out_data  = out_data_ff;
		nxt_out_last  = out_last_ff;
		pkt_ready = 1'b0;
		sdu_ready = 1'b0;
		frm_ready = 1'b0;
		emit      = 1'b0;
		byte_ok   = 1'b1;
		ebyte     = 8'h00;
		d         = 12'h000;
		case (st_ff)
			lpf_pkg::LPF_ST_IDLE: begin
				frm_ready = 1'b1;
				if (frm_valid && frm_bytes != 11'h000) begin
					nxt_rem    = frm_bytes;
					nxt_usable = id_hit || !any_vld;
					nxt_st     = lpf_pkg::LPF_ST_SEL;
				end
			end
			lpf_pkg::LPF_ST_SEL: begin
				nxt_st = lpf_pkg::LPF_ST_PAD;
				if (!usable_ff) begin
					nxt_st = lpf_pkg::LPF_ST_PAD;
				end else if (act_ff) begin
					if (rem12 > lpf_pkg::LPF_HDR_BYTES) begin
						if (left <= rem12 - lpf_pkg::LPF_HDR_BYTES) begin
							d = left;
							nxt_seg_e = 1'b1;
						end else begin
							d = rem12 - lpf_pkg::LPF_HDR_BYTES;
							if (usecrc_ff && left - d < lpf_pkg::LPF_CRC_BYTES) begin
								d = left - lpf_pkg::LPF_CRC_BYTES;
							end
							nxt_seg_e = 1'b0;
						end
						nxt_seg_s  = 1'b0;
						nxt_seglen = d[10:0];
						nxt_cnt    = d[10:0];
						if (d != 12'h000) begin
							nxt_st = lpf_pkg::LPF_ST_HDR0;
						end
					end
				end else if (pkt_valid) begin
					nxt_ptype  = pkt_ptype;
					nxt_sdulen = pkt_len;
					nxt_lab    = n_lab;
					nxt_lbl    = pkt_vnid[7:0];
					nxt_supp   = ctrl_ff[lpf_pkg::LPF_CTRL_SUPP];
					nxt_sig    = pkt_signalling;
					nxt_pos    = 12'h000;
					// Type bytes always enter the check value, even when not sent
					nxt_crc = lpf_pkg::lpf_crc_upd(lpf_pkg::lpf_crc_upd(lpf_pkg::LPF_CRC_INIT,
						pkt_ptype[15:8]), pkt_ptype[7:0]);
					nxt_seg_s = 1'b1;
					if (n_base + lpf_pkg::LPF_HDR_BYTES <= rem12) begin
						pkt_ready  = 1'b1;
						nxt_seg_e  = 1'b1;
						nxt_usecrc = 1'b0;
						nxt_plen   = n_base;
						nxt_seglen = n_base[10:0];
						nxt_cnt    = n_base[10:0];
						nxt_st     = lpf_pkg::LPF_ST_HDR0;
					end else if (rem12 >= lpf_pkg::LPF_START_MIN && has_free
							&& (ctrl_ff[lpf_pkg::LPF_CTRL_ALLOW_CRC]
							|| ctrl_ff[lpf_pkg::LPF_CTRL_ALLOW_SEQ])) begin
						pkt_ready  = 1'b1;
						nxt_seg_e  = 1'b0;
						nxt_usecrc = ctrl_ff[lpf_pkg::LPF_CTRL_ALLOW_CRC];
						nxt_plen   = n_total;
						d = rem12 - lpf_pkg::LPF_START_MIN;
						if (ctrl_ff[lpf_pkg::LPF_CTRL_ALLOW_CRC]
								&& n_total - d < lpf_pkg::LPF_CRC_BYTES) begin
							d = n_total - lpf_pkg::LPF_CRC_BYTES;
						end
						nxt_seglen = 11'(d + lpf_pkg::LPF_HDR_BYTES);
						nxt_cnt    = d[10:0];
						nxt_tag    = free_tag;
						nxt_busy[free_tag] = 1'b1;
						nxt_act    = 1'b1;
						nxt_st     = lpf_pkg::LPF_ST_HDR0;
					end
				end
			end
			lpf_pkg::LPF_ST_HDR0: begin
				emit  = adv;
				ebyte = {seg_s_ff, seg_e_ff, seglen_ff[10:5]};
				if (adv) begin
					nxt_st = lpf_pkg::LPF_ST_HDR1;
				end
			end
			lpf_pkg::LPF_ST_HDR1: begin
				emit  = adv;
				// No segment label bytes, so the next byte follows the header directly
				ebyte = {seglen_ff[4:0], (seg_s_ff && seg_e_ff) ? {ltype, supp_ff} : tag_ff};
				if (adv) begin
					nxt_st = (seg_s_ff && !seg_e_ff) ? lpf_pkg::LPF_ST_SH0 : lpf_pkg::LPF_ST_BODY;
				end
			end
			lpf_pkg::LPF_ST_SH0: begin
				emit  = adv;
				ebyte = {usecrc_ff, plen_ff[11:5]};
				if (adv) begin
					nxt_st = lpf_pkg::LPF_ST_SH1;
				end
			end
			lpf_pkg::LPF_ST_SH1: begin
				emit  = adv;
				ebyte = {plen_ff[4:0], ltype, supp_ff};
				if (adv) begin
					nxt_st = (cnt_ff != 11'h000) ? lpf_pkg::LPF_ST_BODY
						: ((rem_ff == 11'h001) ? lpf_pkg::LPF_ST_IDLE : lpf_pkg::LPF_ST_SEL);
				end
			end
			lpf_pkg::LPF_ST_BODY: begin
				if (pos_ff < hb) begin
					ebyte = (pos_ff == 12'h000) ? ptype_ff[15:8] : ptype_ff[7:0];
				end else if (pos_ff < lb) begin
					ebyte = lbl_ff;
				end else if (pos_ff < sb) begin
					ebyte     = sdu_data;
					byte_ok   = sdu_valid;
					sdu_ready = adv;
				end else if (usecrc_ff) begin
					ebyte = crc_ff[8*(3 - 32'(pos_ff - sb)) +: 8];
				end else begin
					ebyte = seq_ff[tag_ff];
				end
				emit = adv && byte_ok;
				if (emit) begin
					nxt_pos = pos_ff + 12'h001;
					nxt_cnt = cnt_ff - 11'h001;
					if (pos_ff >= hb && pos_ff < sb) begin
						nxt_crc = lpf_pkg::lpf_crc_upd(crc_ff, ebyte);
					end
					if (cnt_ff == 11'h001) begin
						nxt_st = (rem_ff == 11'h001) ? lpf_pkg::LPF_ST_IDLE : lpf_pkg::LPF_ST_SEL;
						if (seg_e_ff) begin
							nxt_pktcnt = pktcnt_ff + 16'h0001;
							nxt_act    = 1'b0;
							if (act_ff) begin
								nxt_busy[tag_ff] = 1'b0;
								if (!usecrc_ff) begin
									nxt_seq[tag_ff] = seq_ff[tag_ff] + 8'h01;
								end
							end
						end
					end
				end
			end
			lpf_pkg::LPF_ST_PAD: begin
				emit  = adv;
				ebyte = 8'h00;
				if (adv && rem_ff == 11'h001) begin
					nxt_st = lpf_pkg::LPF_ST_IDLE;
				end
			end
			default: begin
				nxt_st = lpf_pkg::LPF_ST_IDLE;
			end
		endcase
		if (emit) begin
			nxt_out_valid = 1'b1;
			nxt_out_data  = ebyte;
			nxt_out_last  = rem_ff == 11'h001;
			nxt_rem       = rem_ff - 11'h001;
		end
		if (logon) begin
			for (int i = 0; i < lpf_pkg::LPF_TAGS; i++) begin
				nxt_seq[i] = 8'h00;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= lpf_pkg::LPF_ST_IDLE; rem_ff <= 11'h000;  usable_ff <= 1'b0;
			act_ff <= 1'b0;    usecrc_ff <= 1'b0; lab_ff <= 1'b0;   supp_ff <= 1'b0;
			sig_ff <= 1'b0;    seg_s_ff <= 1'b0;  seg_e_ff <= 1'b0; tag_ff <= 3'h0;
			plen_ff <= 12'h000; pos_ff <= 12'h000; sdulen_ff <= 12'h000;
			ptype_ff <= 16'h0000; pktcnt_ff <= 16'h0000; lbl_ff <= 8'h00; busy_ff <= 8'h00;
			crc_ff <= lpf_pkg::LPF_CRC_INIT; seglen_ff <= 11'h000; cnt_ff <= 11'h000;
			out_valid_ff <= 1'b0; out_data_ff <= 8'h00; out_last_ff <= 1'b0;
			for (int i = 0; i < lpf_pkg::LPF_TAGS; i++) begin
				seq_ff[i] <= 8'h00;
			end
		end else begin
			st_ff <= nxt_st;   rem_ff <= nxt_rem;       usable_ff <= nxt_usable;
			act_ff <= nxt_act; usecrc_ff <= nxt_usecrc; lab_ff <= nxt_lab;
			supp_ff <= nxt_supp; sig_ff <= nxt_sig;     seg_s_ff <= nxt_seg_s;
			seg_e_ff <= nxt_seg_e; tag_ff <= nxt_tag;   plen_ff <= nxt_plen;
			pos_ff <= nxt_pos; sdulen_ff <= nxt_sdulen; ptype_ff <= nxt_ptype;
			pktcnt_ff <= nxt_pktcnt; lbl_ff <= nxt_lbl; busy_ff <= nxt_busy;
			crc_ff <= nxt_crc; seglen_ff <= nxt_seglen; cnt_ff <= nxt_cnt;
			out_valid_ff <= nxt_out_valid; out_data_ff <= nxt_out_data;
			out_last_ff <= nxt_out_last;
			seq_ff <= nxt_seq;
		end
	end

	property p_trailer_excl;
		@(posedge aclk) disable iff (!aresetn)
		act_ff |-> (plen_ff - sb) == (usecrc_ff ? 12'h004 : 12'h001);
	endproperty
	a_trailer_excl: assert property (p_trailer_excl) else $error("trailer size wrong");
	property p_method_allowed;
		@(posedge aclk) disable iff (!aresetn)
		$rose(act_ff) |-> ($past(ctrl_ff[0]) && usecrc_ff) || ($past(ctrl_ff[1]) && !usecrc_ff);
	endproperty
	a_method_allowed: assert property (p_method_allowed) else $error("method not allowed");
	property p_seq_incr;
		@(posedge aclk) disable iff (!aresetn)
		(seg_fin && seg_e_ff && act_ff && !usecrc_ff && !logon)
		|=> seq_ff[$past(tag_ff)] == $past(seq_ff[tag_ff]) + 8'h01;
	endproperty
	a_seq_incr: assert property (p_seq_incr) else $error("sequence not incremented");
	property p_hdr_bits;
		@(posedge aclk) disable iff (!aresetn)
		(st_ff == lpf_pkg::LPF_ST_HDR0 && adv)
		|=> out_valid_ff && out_data_ff[7:6] == $past({seg_s_ff, seg_e_ff});
	endproperty
	a_hdr_bits: assert property (p_hdr_bits) else $error("header flag bits wrong");
	property p_cont_nonempty;
		@(posedge aclk) disable iff (!aresetn)
		(st_ff == lpf_pkg::LPF_ST_HDR0 && !seg_s_ff) |-> seglen_ff != 11'h000;
	endproperty
	a_cont_nonempty: assert property (p_cont_nonempty) else $error("empty segment");
	property p_pad_zero;
		@(posedge aclk) disable iff (!aresetn)
		(st_ff == lpf_pkg::LPF_ST_PAD && adv) |=> out_valid_ff && out_data_ff == 8'h00;
	endproperty
	a_pad_zero: assert property (p_pad_zero) else $error("padding not zero");
	property p_start_len;
		@(posedge aclk) disable iff (!aresetn)
		(st_ff == lpf_pkg::LPF_ST_SH0) |-> seglen_ff == cnt_ff + 11'h002;
	endproperty
	a_start_len: assert property (p_start_len) else $error("start length wrong");
	property p_tag_free;
		@(posedge aclk) disable iff (!aresetn)
		$rose(act_ff) |-> ($past(busy_ff) & (8'h01 << tag_ff)) == 8'h00 && busy_ff[tag_ff];
	endproperty
	a_tag_free: assert property (p_tag_free) else $error("tag already in use");
endmodule : lpf_fragmenter

// ==== verilog/lpf_pkg.sv ====
// Notes on behaviour
// - Check value and sequence number never appear together in one link packet.
// - Fragmented packets use check value or sequence number, only if allowed; flag shows it.
// - A one-byte label can carry the virtual network id when type zero is one byte.
// - Id goes in the label only if enabled and it differs from the default id.
// - An id wider than the label field is cut to its low bits.
// - Signalling payloads carry no label; traffic carries zero or one label byte.
// - At least three assignment ids; frames on any of them are usable by default.
// - Packets are split to fit frames, or sent whole in one full segment.
// - Fragments go start, continuations, end, in order, all with one fragment tag.
// - Per-tag 8-bit wrapping counter, zeroed at logon, appended in end segment, then incremented.
// - Check value covers protocol type, label and packet, even if type is suppressed.
// - Packets in progress each hold a fragment tag no other packet in progress uses.
// - A full segment may sit anywhere, also between fragments of other packets; here no new packet starts while a fragmented one is active.
// - Segment header: start bit, end bit, 11-bit length, three more bits.
// - Full segment tail bits are label type and suppressed flag; others carry the tag.
// - Segment label bytes follow the first header directly; none are used here.
// - Start segment has second header: crc flag, 12-bit total, label type, suppressed flag.
// - A continuation segment always carries at least one packet byte.
// - Header 0x0000 starts padding, which fills the rest of the frame payload.
// - Avoid splitting the last four check-value bytes across frame payloads.
// - Start bit set in first segment, end bit in last, both clear in continuation.
// - Segment length counts the variable part only, without first header and label.
package lpf_pkg;
	localparam logic [7:0]  LPF_OFF_CTRL    = 8'h00;
	localparam logic [7:0]  LPF_OFF_DEFVN   = 8'h04;
	localparam logic [7:0]  LPF_OFF_ASSIGN  = 8'h08;
	localparam logic [7:0]  LPF_OFF_STATUS  = 8'h0c;
	localparam logic [7:0]  LPF_OFF_PKTCNT  = 8'h10;
	localparam int          LPF_CTRL_ALLOW_CRC = 0;
	localparam int          LPF_CTRL_ALLOW_SEQ = 1;
	localparam int          LPF_CTRL_LBL_ONE   = 2;
	localparam int          LPF_CTRL_VN_EN     = 3;
	localparam int          LPF_CTRL_SUPP      = 4;
	localparam int          LPF_CTRL_LOGON     = 5;
	localparam int          LPF_ASSIGN_VLD     = 24;
	localparam int          LPF_ASSIGN_N       = 3;
	localparam int          LPF_TAGS           = 8;
	localparam logic [31:0] LPF_CTRL_RST    = 32'h0000_0001;
	localparam logic [31:0] LPF_DEFVN_RST   = 32'h0000_0000;
	localparam logic [31:0] LPF_ASSIGN_RST  = 32'h0000_0000;
	localparam logic [31:0] LPF_CRC_POLY    = 32'h04c1_1db7;
	localparam logic [31:0] LPF_CRC_INIT    = 32'hffff_ffff;
	localparam logic [1:0]  LPF_LT_ONE      = 2'h0;
	localparam logic [1:0]  LPF_LT_NONE     = 2'h2;
	localparam logic [1:0]  LPF_LT_SIG      = 2'h3;
	localparam logic [11:0] LPF_PT_BYTES    = 12'h002;
	localparam logic [11:0] LPF_HDR_BYTES   = 12'h002;
	localparam logic [11:0] LPF_START_MIN   = 12'h004;
	localparam logic [11:0] LPF_CRC_BYTES   = 12'h004;
	localparam logic [11:0] LPF_SEQ_BYTES   = 12'h001;
	localparam logic [1:0]  LPF_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  LPF_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		LPF_ST_IDLE = 3'h0,
		LPF_ST_SEL  = 3'h1,
		LPF_ST_HDR0 = 3'h2,
		LPF_ST_HDR1 = 3'h3,
		LPF_ST_SH0  = 3'h4,
		LPF_ST_SH1  = 3'h5,
		LPF_ST_BODY = 3'h6,
		LPF_ST_PAD  = 3'h7
	} lpf_state_t;

	function automatic logic [31:0] lpf_crc_upd(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c ^ {d, 24'h000000};
		for (int i = 0; i < 8; i++) begin
			r = r[31] ? ((r << 1) ^ LPF_CRC_POLY) : (r << 1);
		end
		return r;
	endfunction : lpf_crc_upd

	function automatic logic [31:0] lpf_strb(input logic [31:0] o, input logic [31:0] n,
			input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[8*i +: 8] = n[8*i +: 8];
			end
		end
		return r;
	endfunction : lpf_strb
endpackage : lpf_pkg

// ==== tb/lpf_gw_rx.sv ====
`timescale 1ns/1ps
module lpf_gw_rx (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       out_valid,
	output logic            out_ready,
	input  wire logic [7:0] out_data,
	input  wire logic       out_last,
	output logic [3:0]      seg_cnt
);
	logic [10:0] skip_ff;
	logic [7:0]  b0_ff;
	logic [2:0]  cyc_ff;
	logic        hi_ff;
	logic        pad_ff;
	// Stall one cycle in four so the sender must hold the byte it offers then
	assign out_ready = cyc_ff[1:0] != 2'h3;
	always_ff @(posedge aclk) begin
		cyc_ff <= aresetn ? cyc_ff + 3'h1 : 3'h0;
		if (!aresetn) begin
			seg_cnt <= 4'h0;
		end
		if (!aresetn || (out_valid && out_ready && out_last)) begin
			skip_ff <= 11'h0;
			hi_ff   <= 1'b0;
			pad_ff  <= 1'b0;
		end else if (out_valid && out_ready && !pad_ff) begin
			if (skip_ff != 11'h0) begin
				skip_ff <= skip_ff - 11'h1;
			end else begin
				hi_ff <= !hi_ff;
				b0_ff <= out_data;
				if (hi_ff) begin
					skip_ff <= {b0_ff[5:0], out_data[7:3]};
					pad_ff  <= {b0_ff, out_data} == 16'h0;
					seg_cnt <= seg_cnt + {3'h0, {b0_ff, out_data} != 16'h0};
				end
			end
		end
	end
endmodule : lpf_gw_rx

// ==== tb/lpf_fragmenter_tb_top.sv ====
`timescale 1ns/1ps
module lpf_fragmenter_tb_top;
	logic        aclk, aresetn, awv, wv, bry, arv, rry, awr, wr, bv, arr, rv, ov, ordy, ol;
	logic        pv, prdy, sv, srdy, fv, frdy, psig;
	logic [7:0]  awa, ara, sbase, sidx, od, k, aid;
	logic [31:0] wd, rd, r, xcrc;
	logic [3:0]  ws, seg;
	logic [1:0]  bre, rre;
	logic [11:0] plen, pvn;
	logic [15:0] ptyp;
	logic [10:0] fb;
	logic [8:0]  exp_q[$];
	int          num_errors, samples_checked, n;
	lpf_fragmenter i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bre), .s_axi_bvalid(bv),
		.s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd), .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rry),
		.pkt_valid(pv), .pkt_ready(prdy), .pkt_len(plen), .pkt_ptype(ptyp), .pkt_vnid(pvn),
		.pkt_signalling(psig), .sdu_valid(sv), .sdu_ready(srdy), .sdu_data(sbase + sidx),
		.frm_valid(fv), .frm_ready(frdy), .frm_bytes(fb), .frm_assign_id(aid),
		.out_valid(ov), .out_ready(ordy), .out_data(od), .out_last(ol));
	lpf_gw_rx i_rx (.aclk(aclk), .aresetn(aresetn), .out_valid(ov), .out_ready(ordy),
		.out_data(od), .out_last(ol), .seg_cnt(seg));
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	task automatic report_and_stop();
		$display("Checked %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Every wait shares one bound so a hang ends the run
	task automatic tick();
		@(posedge aclk);
		n++;
		if (n > 300) begin
			num_errors++;
			report_and_stop();
		end
	endtask : tick
	always @(posedge aclk) begin
		sidx <= aresetn ? sidx + {7'h0, srdy} : 8'h0;
		if (prdy) pv <= 1'b0;
		if (aresetn && ov && ordy) chk({ol, od}, exp_q.pop_front());
	end
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		awa <= a;
		wd  <= d;
		awv <= 1'b1;
		wv  <= 1'b1;
		bry <= 1'b1;
		n = 0;
		do tick(); while (!awr);
		awv <= 1'b0;
		wv  <= 1'b0;
		do tick(); while (!bv);
		bry <= 1'b0;
		chk(bre, 2'h0);
		// Let an edge pass so a following call never re-raises a strobe in this step
		tick();
	endtask : axw
	task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		n = 0;
		do tick(); while (!arr);
		arv <= 1'b0;
		do tick(); while (!rv);
		rry <= 1'b0;
		chk(rd, d);
		chk(rre, e);
		tick();
	endtask : axr
	task automatic put(input logic [7:0] d);
		exp_q.push_back({1'b0, d});
	endtask : put
	function automatic logic [31:0] crc8(input logic [31:0] v, input logic [7:0] b);
		v = v ^ {b, 24'h000000};
		repeat (8) begin
			v = v[31] ? ((v << 1) ^ lpf_pkg::LPF_CRC_POLY) : (v << 1);
		end
		return v;
	endfunction : crc8
	task automatic pkt(input logic [11:0] l, input logic [1:0] se, input logic [10:0] len,
			input logic [2:0] t);
		r = $urandom;
		xcrc = crc8(crc8(lpf_pkg::LPF_CRC_INIT, r[15:8]), r[7:0]);
		plen <= l;
		ptyp <= r[15:0];
		pv   <= 1'b1;
		put({se, len[10:5]});
		put({len[4:0], t});
	endtask : pkt
	task automatic sdu(input int c);
		repeat (c) begin
			put(sbase + k);
			xcrc = crc8(xcrc, sbase + k);
			k++;
		end
	endtask : sdu
	task automatic frame(input logic [10:0] b);
		while (exp_q.size() < b) put(8'h00);
		exp_q[$][8] = 1'b1;
		fb <= b;
		fv <= 1'b1;
		n = 0;
		do tick(); while (!frdy);
		fv <= 1'b0;
		do tick(); while (exp_q.size() != 0);
	endtask : frame
	initial begin
		{awv, wv, bry, arv, rry, pv, psig, fv, k, sidx, awa, ara, wd, plen, ptyp, fb} = '0;
		void'($urandom(32'h369d2e15));
		sbase = $urandom;
		aid = $urandom;
		pvn = 12'habc;
		ws = 4'hf;
		sv = 1'b1;
		aresetn = 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		axr(8'h00, 32'h1, 2'h0);
		axr(8'h20, 32'h0, 2'h2);
		axw(8'h00, 32'h0d);
		pkt(12'd4, 2'b11, 11'd7, 3'h0);
		put(r[15:8]);
		put(r[7:0]);
		put(8'hbc);
		sdu(4);
		frame(16);
		axw(8'h00, 32'h22);
		for (int i = 0; i < 2; i++) begin
			pkt(12'd10, 2'b10, 11'd6, 3'h0);
			put(8'h00);
			put({5'd13, 3'h4});
			put(r[15:8]);
			put(r[7:0]);
			sdu(2);
			frame(8);
			put(8'h40);
			put({5'd9, 3'h0});
			sdu(8);
			put(i[7:0]);
			frame(16);
		end
		axw(8'h00, 32'h01);
		pkt(12'd6, 2'b10, 11'd6, 3'h0);
		put(8'h80);
		put({5'd12, 3'h4});
		put(r[15:8]);
		put(r[7:0]);
		sdu(2);
		frame(8);
		// Trailer would straddle frames, so the middle piece is cut short
		put(8'h00);
		put({5'd4, 3'h0});
		sdu(4);
		frame(8);
		put(8'h40);
		put({5'd4, 3'h0});
		for (int i = 3; i >= 0; i--) begin
			put(xcrc[8*i +: 8]);
		end
		frame(8);
		axw(8'h08, {8'h01, 16'h0000, aid + 8'h01});
		pv <= 1'b1;
		frame(4);
		axw(8'h08, {8'h04, aid, 16'h0000});
		pkt(12'd3, 2'b11, 11'd5, 3'h4);
		put(r[15:8]);
		put(r[7:0]);
		sdu(3);
		frame(16);
		chk(seg, 4'h9);
		axr(8'h10, 32'h5, 2'h0);
		report_and_stop();
	end
endmodule : lpf_fragmenter_tb_top
